// >>> common/hims_defines.vh
// Functional notes
// - 16-bit enable register, reset zero; bits 15,14,13,11,9,8,6..2 gate sources.
// - interrupt pin high while any status bit and its enable are both set.
// - reading status changes nothing; clearable bits clear only on written one.
// - clearable status bits latch on the event edge and hold until cleared.
// - status bit 15 sets on any link up/down change; write one clears.
// - status bit 14 sets on transmit done with queue ready; write one clears.
// - status bit 13 sets when a received frame awaits host; write one clears.
// - status bit 11 sets on receive overrun; write one clears.
// - status bit 9 sets when transmit process stops; write one clears.
// - status bit 8 sets when receive process stops; write one clears.
// - status bit 6 sets on transmit space available; write one clears.
// - status bit 5 wake frame, read-only; cleared by pattern 1000 in pm[5:2].
// - status bit 4 magic packet, read-only; cleared by pattern 0100 in pm[5:2].
// - enable bit 3 gates linkup wake, enable bit 2 gates energy wake.
// - status bit 3 linkup wake, read-only; cleared by pattern 0010 in pm[5:2].
// - status bit 2 energy wake, delayed when enable bit 0 set; pattern 0001 clears.
`ifndef HIMS_DEFINES_VH
`define HIMS_DEFINES_VH
// register indices as printed, byte address is four times the index
`define HIMS_IDX_MASK 12'h190
`define HIMS_IDX_PEND 12'h192
`define HIMS_IDX_PM 12'h198
`define HIMS_ADDR_MASK 12'h640
`define HIMS_ADDR_PEND 12'h648
`define HIMS_ADDR_PM 12'h660
// field positions
`define HIMS_B_LINK 15
`define HIMS_B_TXDONE 14
`define HIMS_B_RXRDY 13
`define HIMS_B_RXOVR 11
`define HIMS_B_TXSTOP 9
`define HIMS_B_RXSTOP 8
`define HIMS_B_TXSPACE 6
`define HIMS_B_WFRAME 5
`define HIMS_B_MAGIC 4
`define HIMS_B_LWAKE 3
`define HIMS_B_EWAKE 2
`define HIMS_B_EDELAY 0
// implemented bit masks
`define HIMS_MASK_BITS 16'hEB7D
`define HIMS_PEND_BITS 16'hEB7C
`define HIMS_W1C_BITS 16'hEB40
`define HIMS_RST_MASK 16'h0000
`define HIMS_RST_PEND 16'h0000
`define HIMS_RST_PM 4'h0
// wake clear patterns on pm[5:2]
`define HIMS_PM_CLR_WFRAME 4'h8
`define HIMS_PM_CLR_MAGIC 4'h4
`define HIMS_PM_CLR_LWAKE 4'h2
`define HIMS_PM_CLR_EWAKE 4'h1
`endif

// >>> hdl/hims_top.v
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "hims_defines.vh"
module hims_top (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// event sources, same clock, level high while condition holds
	input wire link_up,
	input wire tx_done_ev,
	input wire rx_ready_ev,
	input wire rx_overrun_ev,
	input wire tx_stopped_ev,
	input wire rx_stopped_ev,
	input wire tx_space_ev,
	input wire wake_frame_ev,
	input wire magic_pkt_ev,
	input wire linkup_wake_ev,
	input wire energy_wake_ev,
	// controls and interrupt
	output wire energy_delay_mode,
	output wire irq
);

reg [15:0] irq_mask_reg_r;
reg [15:0] irq_mask_reg_nxt;
reg [15:0] irq_pending_reg_r;
reg [15:0] irq_pending_reg_nxt;
reg [3:0] power_mgmt_control_r;
reg [15:0] src_prev_r;
reg link_seen_r;
wire [15:0] src_lvl;
wire [15:0] src_edge;
wire [15:0] set_vec;
wire [15:0] clr_vec;
wire hit_mask;
wire hit_pend;
wire hit_pm;
wire mapped;
wire wr_acc;
wire [15:0] wdata16;
wire [15:0] lane16;
wire [3:0] pm_pat;

// zero wait states, so every access phase completes at once
assign pready = 1'b1;
assign hit_mask = (paddr == `HIMS_ADDR_MASK);
assign hit_pend = (paddr == `HIMS_ADDR_PEND);
assign hit_pm = (paddr == `HIMS_ADDR_PM);
assign mapped = hit_mask | hit_pend | hit_pm;
// unmapped addresses answer with an error and change nothing
assign pslverr = psel & penable & ~mapped;
assign wr_acc = psel & penable & pwrite & mapped;
assign wdata16 = pwdata[15:0];
assign lane16 = {{8{pstrb[1]}}, {8{pstrb[0]}}};
assign pm_pat = pwdata[5:2];

// source levels placed at their status positions
assign src_lvl = {1'b0, tx_done_ev, rx_ready_ev, 1'b0,
	rx_overrun_ev, 1'b0, tx_stopped_ev, rx_stopped_ev,
	1'b0, tx_space_ev, wake_frame_ev, magic_pkt_ev,
	linkup_wake_ev, energy_wake_ev, 2'b00};

// rising edges latch, levels never feed the flags directly
assign src_edge = src_lvl & ~src_prev_r;

// set requests; link change counts both directions
assign set_vec = {link_seen_r & (link_up ^ src_prev_r[15]),
	src_edge[14:0]} & `HIMS_PEND_BITS;

// write-one clears for the w1c group only
assign clr_vec = (wr_acc & hit_pend) ?
	(wdata16 & lane16 & `HIMS_W1C_BITS) : 16'h0000;

// event history; link history starts after the first sampled cycle
// so a link already up at reset is not taken for a change
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		src_prev_r <= 16'h0000;
		link_seen_r <= 1'b0;
	end else begin
		src_prev_r <= {link_up, src_lvl[14:0]};
		link_seen_r <= 1'b1;
	end
end

// enable register, reserved positions stay zero
always @* begin
	irq_mask_reg_nxt = irq_mask_reg_r;
	if (wr_acc && hit_mask) begin
		irq_mask_reg_nxt = ((wdata16 & lane16) |
			(irq_mask_reg_r & ~lane16)) & `HIMS_MASK_BITS;
	end
end

// pending flags: set wins over a clear in the same cycle
always @* begin
	irq_pending_reg_nxt = (irq_pending_reg_r & ~clr_vec) | set_vec;
	if (wr_acc && hit_pm && pstrb[0]) begin
		if (pm_pat == `HIMS_PM_CLR_WFRAME)
			irq_pending_reg_nxt[`HIMS_B_WFRAME] =
				set_vec[`HIMS_B_WFRAME];
		if (pm_pat == `HIMS_PM_CLR_MAGIC)
			irq_pending_reg_nxt[`HIMS_B_MAGIC] =
				set_vec[`HIMS_B_MAGIC];
		if (pm_pat == `HIMS_PM_CLR_LWAKE)
			irq_pending_reg_nxt[`HIMS_B_LWAKE] =
				set_vec[`HIMS_B_LWAKE];
		if (pm_pat == `HIMS_PM_CLR_EWAKE)
			irq_pending_reg_nxt[`HIMS_B_EWAKE] =
				set_vec[`HIMS_B_EWAKE];
	end
end

// register state
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_mask_reg_r <= `HIMS_RST_MASK;
		irq_pending_reg_r <= `HIMS_RST_PEND;
		power_mgmt_control_r <= `HIMS_RST_PM;
	end else begin
		irq_mask_reg_r <= irq_mask_reg_nxt;
		irq_pending_reg_r <= irq_pending_reg_nxt;
		if (wr_acc && hit_pm && pstrb[0])
			power_mgmt_control_r <= pm_pat;
	end
end

// read data captured in setup so it stands through the access phase;
// reads have no side effect on any flag
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
	end else if (psel && !penable && !pwrite) begin
		if (hit_mask)
			prdata <= {16'h0000, irq_mask_reg_r};
		else if (hit_pend)
			prdata <= {16'h0000, irq_pending_reg_r};
		else if (hit_pm)
			prdata <= {26'h0000000, power_mgmt_control_r, 2'b00};
		else
			prdata <= 32'h00000000;
	end
end

// delayed energy wake selection goes back to the energy detector
assign energy_delay_mode = irq_mask_reg_r[`HIMS_B_EDELAY];

// level interrupt, falls as soon as nothing enabled is pending
assign irq = |(irq_pending_reg_r & irq_mask_reg_r &
	`HIMS_PEND_BITS);

endmodule // hims_top

// >>> verif/hims_host.sv
`timescale 1ns/1ps
// host cpu: apb master, one transfer at a time
module hims_host (
	input wire pclk, pready, pslverr,
	input wire [31:0] prdata,
	output logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0,
	output logic [11:0] paddr = 12'h000,
	output logic [31:0] pwdata = 32'h0,
	output logic [3:0] pstrb = 4'h0
);
	logic [31:0] q;
	logic e;
	// request held until pready is seen high at an edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
endmodule // hims_host

// >>> verif/hims_chk_asserts.sv
`timescale 1ns/1ps
module hims_chk (
	input wire pclk, presetn, psel, penable, pwrite, pslverr, irq,
	input wire energy_delay_mode,
	input wire [3:0] pstrb,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase and address decode
	wire acc = psel && penable;
	wire map = paddr == 12'h640 || paddr == 12'h648 || paddr == 12'h660;
	wire rd = acc && !pwrite;
	sequence s_mw; acc && pwrite && paddr == 12'h640 && pstrb[0]; endsequence
	property p_err; pslverr |-> acc && !map; endproperty
	a_err: assert property (p_err) else $error("stray pslverr");
	property p_unm; acc && !map |-> pslverr; endproperty
	a_unm: assert property (p_unm) else $error("no pslverr");
	property p_hi; rd |-> prdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
	property p_prsv;
		rd && paddr == 12'h648 |-> (prdata[15:0] & 16'h1483) == 16'h0000;
	endproperty
	a_prsv: assert property (p_prsv) else $error("status reserved");
	property p_ersv;
		rd && paddr == 12'h640 |-> (prdata[15:0] & 16'h1482) == 16'h0000;
	endproperty
	a_ersv: assert property (p_ersv) else $error("enable reserved");
	// irq can only drop after a write, never after a read
	property p_fall; $fell(irq) |-> $past(acc && pwrite); endproperty
	a_fall: assert property (p_fall) else $error("irq fell");
	property p_edm; s_mw |=> energy_delay_mode == $past(pwdata[0]); endproperty
	a_edm: assert property (p_edm) else $error("delay mode");
	property p_hold; $changed(prdata) |-> $past(psel && !penable && !pwrite);
	endproperty
	a_hold: assert property (p_hold) else $error("prdata moved");
endmodule // hims_chk
bind hims_top hims_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.pslverr, .irq, .energy_delay_mode, .pstrb, .paddr, .pwdata, .prdata);

// >>> verif/hims_tb_top.sv
`timescale 1ns/1ps
module hims_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, link_up = 1'b0;
	logic [9:0] ev = 10'h000;
	wire psel, penable, pwrite, pready, pslverr, edm, irq;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [3:0] pstrb;
	int fail_count = 0, comparisons = 0;
	int pos[10] = '{14, 13, 11, 9, 8, 6, 5, 4, 3, 2};
	always #50 pclk = ~pclk;
	hims_host u_host (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb);
	hims_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .link_up,
		.tx_done_ev(ev[0]), .rx_ready_ev(ev[1]), .rx_overrun_ev(ev[2]),
		.tx_stopped_ev(ev[3]), .rx_stopped_ev(ev[4]), .tx_space_ev(ev[5]),
		.wake_frame_ev(ev[6]), .magic_pkt_ev(ev[7]),
		.linkup_wake_ev(ev[8]), .energy_wake_ev(ev[9]),
		.energy_delay_mode(edm), .irq);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h0, 4'h0);
		chk(u_host.q, e);
	endtask
	task t_reset;
		rd(12'h640, 32'h0);
		rd(12'h648, 32'h0);
		u_host.xfer(1'b1, 12'h640, 32'hFFFF, 4'h1);
		rd(12'h640, 32'h007D);
		chk(edm, 1'b1);
		u_host.xfer(1'b1, 12'h640, 32'hFFFF, 4'h3);
		rd(12'h640, 32'hEB7D);
		rd(12'h004, 32'h0);
		chk(u_host.e, 1'b1);
	endtask
	// each source except link_up in turn; wake bits ignore write-one, need the pm pattern
	task t_events;
		for (int i = 0; i < 10; i++) begin
			ev[i] <= 1'b1;
			repeat (3) @(posedge pclk);
			ev[i] <= 1'b0;
			rd(12'h648, 32'h1 << pos[i]);
			chk(irq, 1'b1);
			u_host.xfer(1'b1, 12'h648, 32'hFFFF, 4'h3);
			rd(12'h648, pos[i] < 6 ? 32'h1 << pos[i] : 32'h0);
			u_host.xfer(1'b1, 12'h660, 32'h1 << pos[i], 4'h1);
			rd(12'h648, 32'h0);
			chk(irq, 1'b0);
		end
	endtask
	task t_mask;
		u_host.xfer(1'b1, 12'h640, 32'h4000, 4'h3);
		// a pattern that is not exact must leave the wake flag alone
		ev[6] <= 1'b1;
		@(posedge pclk);
		ev[6] <= 1'b0;
		u_host.xfer(1'b1, 12'h660, 32'h30, 4'h1);
		rd(12'h648, 32'h0020);
		rd(12'h660, 32'h0030);
		u_host.xfer(1'b1, 12'h660, 32'h20, 4'h1);
		rd(12'h648, 32'h0);
		link_up <= 1'b1;
		@(posedge pclk);
		rd(12'h648, 32'h8000);
		chk(irq, 1'b0);
		u_host.xfer(1'b1, 12'h648, 32'h8000, 4'h2);
		link_up <= 1'b0;
		ev[0] <= 1'b1;
		@(posedge pclk);
		rd(12'h648, 32'hC000);
		chk(irq, 1'b1);
		ev[0] <= 1'b0;
		u_host.xfer(1'b1, 12'h648, 32'hC000, 4'h2);
		chk(irq, 1'b0);
	endtask
	task end_sim;
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_events();
		t_mask();
		end_sim();
	end
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge pclk);
		fail_count++;
		end_sim();
	end
endmodule // hims_tb_top
